/* hdl/oorx_defines.svh */
// What this block does
// - On-off keying runs while the modulation type field holds the OOK code.
// - Data rate is one sixteen-bit field over two consecutive registers.
// - Manchester enable bit doubles the effective symbol rate.
// - In OOK, skip bit and filter set field pick the channel bandwidth.
// - Oversampling ratio is eleven bits over its register and offset-high.
// - Filter register: skip bit 7, exponent bits 6:4, filter set 3:0.
`ifndef OORX_DEFINES_SVH
`define OORX_DEFINES_SVH

// Register indices; byte address is four times the index
`define OORX_IDX_IFBW 8'h1C
`define OORX_IDX_OSR 8'h20
`define OORX_IDX_OFS_HI 8'h21
`define OORX_IDX_OFS_MID 8'h22
`define OORX_IDX_OFS_LO 8'h23
`define OORX_IDX_GAIN_HI 8'h24
`define OORX_IDX_GAIN_LO 8'h25
`define OORX_IDX_RATE_HI 8'h6E
`define OORX_IDX_RATE_LO 8'h6F
`define OORX_IDX_MOD_ONE 8'h70
`define OORX_IDX_MOD_TWO 8'h71
`define OORX_IDX_STATUS 8'h72
`define OORX_IDX_BW_HI 8'h73
`define OORX_IDX_BW_LO 8'h74

// Number of writable configuration registers
`define OORX_NCFG 11

// Reset value of every configuration register
`define OORX_CFG_RST 8'h00

// Filter bandwidth register fields
`define OORX_SKIP_BIT 7
`define OORX_DEXP_HI 6
`define OORX_DEXP_LO 4
`define OORX_FSET_HI 3
`define OORX_FSET_LO 0

// Modulation control fields
`define OORX_MANCH_BIT 1
`define OORX_SCALE_BIT 5
`define OORX_MODTYP_HI 1
`define OORX_MODTYP_LO 0

// Split fields inside the offset-high and gain-high registers
`define OORX_OSR_LSB_HI 7
`define OORX_OSR_LSB_LO 5
`define OORX_NCO_MSB_HI 3
`define OORX_NCO_MSB_LO 0
`define OORX_GAIN_MSB_HI 2
`define OORX_GAIN_MSB_LO 0

// Status register bits
`define OORX_ST_OOK_BIT 0
`define OORX_ST_BWV_BIT 1
`define OORX_ST_MAN_BIT 2

`endif

/* hdl/oorx_pkg.sv */
package oorx_pkg;

    // Register slot selected by the address decoder
    typedef enum logic [3:0] {
        SLOT_IFBW = 4'b0000,
        SLOT_OSR = 4'b0001,
        SLOT_OFS_HI = 4'b0010,
        SLOT_OFS_MID = 4'b0011,
        SLOT_OFS_LO = 4'b0100,
        SLOT_GAIN_HI = 4'b0101,
        SLOT_GAIN_LO = 4'b0110,
        SLOT_RATE_HI = 4'b0111,
        SLOT_RATE_LO = 4'b1000,
        SLOT_MOD_ONE = 4'b1001,
        SLOT_MOD_TWO = 4'b1010,
        SLOT_STATUS = 4'b1011,
        SLOT_BW_HI = 4'b1100,
        SLOT_BW_LO = 4'b1101,
        SLOT_NONE = 4'b1111
    } oorx_slot_t;

    // Bus answer phase of the slave
    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_ANSWER = 2'b01
    } oorx_apb_st_t;

endpackage : oorx_pkg

/* hdl/oorx_bw_lut.sv */
`timescale 1ns/1ps
`include "oorx_defines.svh"

module oorx_bw_lut
    import oorx_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Filter selection
    input wire logic ook_en,
    input wire logic skip,
    input wire logic [3:0] fset,
    // Bandwidth in tenths of a kHz
    output logic [12:0] bw_x10,
    output logic bw_valid
);

    logic [12:0] bw_nxt;

    // Channel bandwidth table, tenths of kHz; zero marks an unlisted pair
    always_comb begin
        bw_nxt = 13'h0000;
        if (!skip) begin
            unique case (fset)
                4'h1: bw_nxt = 13'h02F0;
                4'h2: bw_nxt = 13'h0340;
                4'h3: bw_nxt = 13'h0384;
                4'h4: bw_nxt = 13'h03B9;
                4'h5: bw_nxt = 13'h0461;
                4'h6: bw_nxt = 13'h04FF;
                4'h7: bw_nxt = 13'h0563;
                default: bw_nxt = 13'h0000;
            endcase
        end else begin
            unique case (fset)
                4'hF: bw_nxt = 13'h077B;
                4'h1: bw_nxt = 13'h08CB;
                4'h2: bw_nxt = 13'h09B8;
                4'h3: bw_nxt = 13'h0A85;
                4'h4: bw_nxt = 13'h0B21;
                4'h8: bw_nxt = 13'h0D1B;
                4'h9: bw_nxt = 13'h0E22;
                4'hA: bw_nxt = 13'h106A;
                4'hB: bw_nxt = 13'h124C;
                4'hC: bw_nxt = 13'h1444;
                4'hD: bw_nxt = 13'h168A;
                4'hE: bw_nxt = 13'h183F;
                default: bw_nxt = 13'h0000;
            endcase
        end
    end

    // Only OOK uses this table; other modes report no bandwidth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_x10 <= 13'h0000;
            bw_valid <= 1'b0;
        end else begin
            bw_x10 <= ook_en ? bw_nxt : 13'h0000;
            bw_valid <= ook_en && (bw_nxt != 13'h0000);
        end
    end

endmodule : oorx_bw_lut

/* hdl/oorx_cfg.sv */
`timescale 1ns/1ps
`include "oorx_defines.svh"

module oorx_cfg
    import oorx_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter logic [1:0] OOK_CODE = 2'b01
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Modulation and rate
    output logic ook_mode,
    output logic [15:0] data_rate,
    output logic rate_fine,
    output logic manch_en,
    output logic [16:0] symbol_rate,
    // Channel filter
    output logic decim_three_skip,
    output logic [2:0] decim_exp,
    output logic [3:0] filter_set,
    output logic [12:0] bw_x10,
    output logic bw_valid,
    // Clock recovery
    output logic [10:0] osr,
    output logic [19:0] nco_offset,
    output logic [10:0] loop_gain
);

    // Index decode reads eight index bits, so the bus needs ten address bits
    if (ADDR_W < 10) begin : g_addr_chk
        $error("ADDR_W too small for the register map");
    end

    // Configuration byte store and bus state
    logic [7:0] cfg_r [0:`OORX_NCFG-1];
    oorx_apb_st_t st_r;
    oorx_apb_st_t st_nxt;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Registered decoded outputs
    logic ook_mode_r;
    logic [15:0] data_rate_r;
    logic rate_fine_r;
    logic manch_en_r;
    logic [16:0] symbol_rate_r;
    logic decim_three_skip_r;
    logic [2:0] decim_exp_r;
    logic [3:0] filter_set_r;
    logic [10:0] osr_r;
    logic [19:0] nco_offset_r;
    logic [10:0] loop_gain_r;

    // Address split: word index and alignment
    wire [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
    wire aligned = (paddr[1:0] == 2'b00);
    // Index bits above the eighth must be clear, or the access is unmapped
    wire idx_fits = ((word_idx >> 8) == '0);
    wire [7:0] idx8 = word_idx[7:0];

    // Address decode to a register slot
    // Unlisted indices land on the none slot and draw an error
    oorx_slot_t slot;
    assign slot = (!aligned || !idx_fits) ? SLOT_NONE :
        (idx8 == `OORX_IDX_IFBW) ? SLOT_IFBW :
        (idx8 == `OORX_IDX_OSR) ? SLOT_OSR :
        (idx8 == `OORX_IDX_OFS_HI) ? SLOT_OFS_HI :
        (idx8 == `OORX_IDX_OFS_MID) ? SLOT_OFS_MID :
        (idx8 == `OORX_IDX_OFS_LO) ? SLOT_OFS_LO :
        (idx8 == `OORX_IDX_GAIN_HI) ? SLOT_GAIN_HI :
        (idx8 == `OORX_IDX_GAIN_LO) ? SLOT_GAIN_LO :
        (idx8 == `OORX_IDX_RATE_HI) ? SLOT_RATE_HI :
        (idx8 == `OORX_IDX_RATE_LO) ? SLOT_RATE_LO :
        (idx8 == `OORX_IDX_MOD_ONE) ? SLOT_MOD_ONE :
        (idx8 == `OORX_IDX_MOD_TWO) ? SLOT_MOD_TWO :
        (idx8 == `OORX_IDX_STATUS) ? SLOT_STATUS :
        (idx8 == `OORX_IDX_BW_HI) ? SLOT_BW_HI :
        (idx8 == `OORX_IDX_BW_LO) ? SLOT_BW_LO : SLOT_NONE;

    // Slot classes; the readback slots refuse writes
    wire is_cfg = (slot <= SLOT_MOD_TWO);
    wire is_ro = (slot == SLOT_STATUS) || (slot == SLOT_BW_HI) ||
        (slot == SLOT_BW_LO);
    wire hit = is_cfg || is_ro;
    wire bad = !hit || (pwrite && is_ro);

    // Bus phases
    wire setup_ph = psel && !penable;
    wire done_ph = psel && penable && pready_r;
    wire wr_en = done_ph && pwrite && is_cfg && pstrb[0];

    // Status byte shows the decoded state of the modem
    wire [7:0] status_byte = {5'b00000,
        manch_en_r, bw_valid, ook_mode_r};

    // Read data selection; bits above the byte read as zero
    wire [7:0] rd_byte = is_cfg ? cfg_r[slot[3:0]] :
        (slot == SLOT_STATUS) ? status_byte :
        (slot == SLOT_BW_HI) ? {3'b000, bw_x10[12:8]} :
        (slot == SLOT_BW_LO) ? bw_x10[7:0] : 8'h00;

    // Bus state: answer in the access phase right after setup
    // There are no wait states, so the answer follows setup alone
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            APB_IDLE: if (setup_ph) st_nxt = APB_ANSWER;
            APB_ANSWER: st_nxt = setup_ph ? APB_ANSWER : APB_IDLE;
            default: st_nxt = APB_IDLE; // Unused codes fall back to idle
        endcase
        if (done_ph && setup_ph) st_nxt = APB_ANSWER;
    end

    // Bus phase and answer strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= APB_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pready_r <= (st_nxt == APB_ANSWER);
            pslverr_r <= setup_ph && bad;
        end
    end

    // Read data captured at setup so prdata stands as a flop output
    // through the access phase, even if a field changes under it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
        end
    end

    // Configuration store; written only at the completing access edge
    // A cleared low byte strobe drops the write without an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `OORX_NCFG; i++) begin
                cfg_r[i] <= `OORX_CFG_RST;
            end
        end else if (wr_en) begin
            cfg_r[slot[3:0]] <= pwdata[7:0];
        end
    end

    // Named views of the stored bytes
    // Only bytes read in part need a view of their own
    wire [7:0] ifbw = cfg_r[SLOT_IFBW];
    wire [7:0] mod_one = cfg_r[SLOT_MOD_ONE];
    wire [7:0] mod_two = cfg_r[SLOT_MOD_TWO];
    wire [7:0] ofs_hi = cfg_r[SLOT_OFS_HI];
    wire [7:0] gain_hi = cfg_r[SLOT_GAIN_HI];

    // Modulation type compare selects on-off keying
    // Any other code keeps the lookup dark and the status bit clear
    wire ook_nxt =
        (mod_two[`OORX_MODTYP_HI:`OORX_MODTYP_LO] == OOK_CODE);

    // Rate field, high byte at the lower address
    wire [15:0] rate_nxt =
        {cfg_r[SLOT_RATE_HI], cfg_r[SLOT_RATE_LO]};

    // Host picks the fine scale for slow links; stored as given
    wire fine_nxt = mod_one[`OORX_SCALE_BIT];

    // Manchester doubles the symbol rate seen by the recovery loop
    wire manch_nxt = mod_one[`OORX_MANCH_BIT];
    wire [16:0] sym_nxt = manch_nxt ? {rate_nxt, 1'b0} :
        {1'b0, rate_nxt};

    // Filter register fields
    wire skip_nxt = ifbw[`OORX_SKIP_BIT];
    wire [2:0] dexp_nxt = ifbw[`OORX_DEXP_HI:`OORX_DEXP_LO];
    wire [3:0] fset_nxt = ifbw[`OORX_FSET_HI:`OORX_FSET_LO];

    // Eleven-bit ratio: top bits in the lower register
    // The host rounds the ratio; the stored whole value is used as is
    wire [10:0] osr_nxt = {cfg_r[SLOT_OSR],
        ofs_hi[`OORX_OSR_LSB_HI:`OORX_OSR_LSB_LO]};

    // Twenty-bit offset over three registers; value per host formula
    // Bit 4 of offset-high belongs to no field; it only reads back
    wire [19:0] nco_nxt = {ofs_hi[`OORX_NCO_MSB_HI:`OORX_NCO_MSB_LO],
        cfg_r[SLOT_OFS_MID], cfg_r[SLOT_OFS_LO]};

    // Eleven-bit loop gain over two registers
    // Bits 7:3 of gain-high belong to no field; they only read back
    wire [10:0] gain_nxt = {gain_hi[`OORX_GAIN_MSB_HI:`OORX_GAIN_MSB_LO],
        cfg_r[SLOT_GAIN_LO]};

    // Bandwidth lookup, gated by OOK mode
    oorx_bw_lut u_bw_lut (
        .pclk(pclk),
        .presetn(presetn),
        .ook_en(ook_nxt),
        .skip(skip_nxt),
        .fset(fset_nxt),
        .bw_x10(bw_x10),
        .bw_valid(bw_valid)
    );

    // Modulation flags lag a write by one clock, matching the lookup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ook_mode_r <= 1'b0;
            rate_fine_r <= 1'b0;
            manch_en_r <= 1'b0;
        end else begin
            ook_mode_r <= ook_nxt;
            rate_fine_r <= fine_nxt;
            manch_en_r <= manch_nxt;
        end
    end

    // Rate and symbol rate move together, so no cycle shows a mixed pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_rate_r <= 16'h0000;
            symbol_rate_r <= 17'h00000;
        end else begin
            data_rate_r <= rate_nxt;
            symbol_rate_r <= sym_nxt;
        end
    end

    // Channel filter fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decim_three_skip_r <= 1'b0;
            decim_exp_r <= 3'h0;
            filter_set_r <= 4'h0;
        end else begin
            decim_three_skip_r <= skip_nxt;
            decim_exp_r <= dexp_nxt;
            filter_set_r <= fset_nxt;
        end
    end

    // Oversampling ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osr_r <= 11'h000;
        end else begin
            osr_r <= osr_nxt;
        end
    end

    // Recovery offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco_offset_r <= 20'h00000;
        end else begin
            nco_offset_r <= nco_nxt;
        end
    end

    // Timing loop gain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_gain_r <= 11'h000;
        end else begin
            loop_gain_r <= gain_nxt;
        end
    end

    // Bus outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Modulation outputs
    assign ook_mode = ook_mode_r;
    assign rate_fine = rate_fine_r;
    assign manch_en = manch_en_r;

    // Rate outputs
    assign data_rate = data_rate_r;
    assign symbol_rate = symbol_rate_r;

    // Filter outputs
    assign decim_three_skip = decim_three_skip_r;
    assign decim_exp = decim_exp_r;
    assign filter_set = filter_set_r;

    // Clock recovery outputs
    assign osr = osr_r;
    assign nco_offset = nco_offset_r;
    assign loop_gain = loop_gain_r;

endmodule : oorx_cfg

/* dv/oorx_checker.sv */
`timescale 1ns/1ps
module oorx_checker #(
    parameter int ADDR_W = 12,
    parameter logic [1:0] OOK_CODE = 2'b01
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // Modem view
    input wire logic ook_mode,
    input wire logic [15:0] data_rate,
    input wire logic manch_en,
    input wire logic [16:0] symbol_rate,
    input wire logic [12:0] bw_x10,
    input wire logic bw_valid,
    input wire logic [10:0] osr,
    input wire logic [19:0] nco_offset
);
    // A write that really lands; a cleared low byte strobe drops it
    logic wr_hit;
    assign wr_hit = psel && penable && pready && pwrite && pstrb[0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answers and field placement, outputs one clock behind the store
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("No answer after setup cycle");
    a_err_align: assert property (
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("Unaligned access not refused");
    a_ook_select: assert property (wr_hit &&
        paddr == ADDR_W'(12'h1C4) |-> ##2
        ook_mode == ($past(pwdata[1:0], 2) == OOK_CODE))
        else $error("Modulation select does not follow its field");
    a_rate_high: assert property (wr_hit &&
        paddr == ADDR_W'(12'h1B8) |-> ##2
        data_rate[15:8] == $past(pwdata[7:0], 2))
        else $error("Rate high byte misplaced");
    a_osr_high: assert property (wr_hit &&
        paddr == ADDR_W'(12'h080) |-> ##2
        osr[10:3] == $past(pwdata[7:0], 2))
        else $error("Oversampling top bits misplaced");
    a_offset_low: assert property (wr_hit &&
        paddr == ADDR_W'(12'h08C) |-> ##2
        nco_offset[7:0] == $past(pwdata[7:0], 2))
        else $error("Offset low byte misplaced");
    a_symbol_rate: assert property (symbol_rate ==
        (manch_en ? {data_rate, 1'b0} : {1'b0, data_rate}))
        else $error("Symbol rate not matched to coding");
    a_bw_off: assert property (!ook_mode [*3] |->
        !bw_valid && bw_x10 == 13'h0)
        else $error("Bandwidth shown outside on-off keying");
endmodule : oorx_checker

bind oorx_cfg oorx_checker #(.ADDR_W(ADDR_W), .OOK_CODE(OOK_CODE)) u_chk (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .pready, .pslverr, .ook_mode, .data_rate, .manch_en, .symbol_rate,
    .bw_x10, .bw_valid, .osr, .nco_offset);

/* dv/oorx_host.sv */
`timescale 1ns/1ps
module oorx_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request side
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // Answer side
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end

    // One transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic [11:0] a, input logic w,
        input logic [7:0] d, input logic s0,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        pstrb <= {3'h7, s0};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // Slow link: 1.2 kbps, plain coding, 75 kHz filter
    task automatic load_row();
        logic [31:0] r;
        logic e;
        xfer(12'h070, 1'b1, 8'h41, 1'b1, r, e);
        xfer(12'h080, 1'b1, 8'h1A, 1'b1, r, e);
        xfer(12'h084, 1'b1, 8'h00, 1'b1, r, e);
        xfer(12'h088, 1'b1, 8'h9D, 1'b1, r, e);
        xfer(12'h08C, 1'b1, 8'h49, 1'b1, r, e);
        xfer(12'h090, 1'b1, 8'h01, 1'b1, r, e);
        xfer(12'h094, 1'b1, 8'h3D, 1'b1, r, e);
        xfer(12'h1B8, 1'b1, 8'h09, 1'b1, r, e);
        xfer(12'h1BC, 1'b1, 8'hD5, 1'b1, r, e);
        xfer(12'h1C0, 1'b1, 8'h20, 1'b1, r, e);
        xfer(12'h1C4, 1'b1, 8'h01, 1'b1, r, e);
    endtask : load_row
endmodule : oorx_host

/* dv/ook_rx_modem_clock_recovery_config_tb_top.sv */
`timescale 1ns/1ps
module ook_rx_modem_clock_recovery_config_tb_top;
    // Bus, modem outputs and score
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, filter_set;
    logic ook_mode, rate_fine, manch_en, decim_three_skip, bw_valid;
    logic [15:0] data_rate;
    logic [16:0] symbol_rate;
    logic [2:0] decim_exp;
    logic [12:0] bw_x10;
    logic [10:0] osr, loop_gain;
    logic [19:0] nco_offset;
    int err_count, samples_checked;

    oorx_cfg uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .ook_mode, .data_rate,
        .rate_fine, .manch_en, .symbol_rate, .decim_three_skip, .decim_exp,
        .filter_set, .bw_x10, .bw_valid, .osr, .nco_offset, .loop_gain);
    oorx_host host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr);

    // Clock
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Write, then let the one-clock output latency land
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        host.xfer(a, 1'b1, d, 1'b1, r, e);
        repeat (2) @(posedge pclk);
    endtask : wr

    task automatic t_reset();
        logic [11:0] regs[11] = '{12'h070, 12'h080, 12'h084, 12'h088,
            12'h08C, 12'h090, 12'h094, 12'h1B8, 12'h1BC, 12'h1C0, 12'h1C4};
        logic [31:0] r;
        logic e;
        foreach (regs[i]) begin
            host.xfer(regs[i], 1'b0, 8'h00, 1'b1, r, e);
            chk("reset value", {r[31:1], r[0] | e}, 32'h0);
        end
    endtask : t_reset

    task automatic t_row();
        logic [31:0] r;
        logic e;
        host.load_row();
        repeat (2) @(posedge pclk);
        chk("ook", {31'h0, ook_mode}, 32'h1);
        chk("rate", {16'h0, data_rate}, 32'h9D5);
        chk("scale", {31'h0, rate_fine}, 32'h1);
        chk("symbol", {15'h0, symbol_rate}, 32'h9D5);
        chk("filter", {24'h0, decim_three_skip, decim_exp, filter_set},
            32'h41);
        chk("bw", {18'h0, bw_valid, bw_x10}, 32'h22F0);
        chk("osr", {21'h0, osr}, 32'h0D0);
        chk("offset", {12'h0, nco_offset}, 32'h9D49);
        chk("gain", {21'h0, loop_gain}, 32'h13D);
        host.xfer(12'h094, 1'b0, 8'h00, 1'b1, r, e);
        chk("gain readback", r, 32'h3D);
    endtask : t_row

    task automatic t_manch();
        wr(12'h1C0, 8'h22);
        chk("manch", {31'h0, manch_en}, 32'h1);
        chk("symbol x2", {15'h0, symbol_rate}, 32'h13AA);
    endtask : t_manch

    // Listed pairs, an ignored exponent and an unlisted setting
    task automatic t_bw();
        logic [7:0] cfg[5] = '{8'h47, 8'h8F, 8'h8E, 8'h71, 8'h08};
        logic [13:0] want[5] = '{14'h2563, 14'h277B, 14'h383F, 14'h22F0,
            14'h0000};
        foreach (cfg[i]) begin
            wr(12'h070, cfg[i]);
            chk("bw", {18'h0, bw_valid, bw_x10}, {18'h0, want[i]});
            chk("skip", {31'h0, decim_three_skip}, 32'(cfg[i][7]));
        end
    endtask : t_bw

    // Every modulation code, ending on the one for on-off keying
    task automatic t_mod();
        logic [1:0] c;
        wr(12'h070, 8'h47);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i + 2);
            wr(12'h1C4, {6'h0, c});
            chk("ook code", {31'h0, ook_mode}, {31'h0, c == 2'h1});
            chk("bw valid", {31'h0, bw_valid}, {31'h0, c == 2'h1});
        end
    endtask : t_mod

    task automatic t_refuse();
        logic [31:0] r;
        logic e;
        host.xfer(12'h000, 1'b0, 8'h00, 1'b1, r, e);
        chk("unmapped", {r[31:1], e}, 32'h1);
        host.xfer(12'h071, 1'b0, 8'h00, 1'b1, r, e);
        chk("unaligned", {31'h0, e}, 32'h1);
        host.xfer(12'h1C8, 1'b1, 8'hFF, 1'b1, r, e);
        chk("status write", {31'h0, e}, 32'h1);
        host.xfer(12'h080, 1'b1, 8'h55, 1'b0, r, e);
        repeat (2) @(posedge pclk);
        chk("no strobe", {21'h0, osr}, 32'h0D0);
        host.xfer(12'h1C8, 1'b0, 8'h00, 1'b1, r, e);
        chk("status", r, 32'h7);
        host.xfer(12'h1CC, 1'b0, 8'h00, 1'b1, r, e);
        chk("bw high", {e, r[30:0]}, 32'h0000_0005);
        host.xfer(12'h1D0, 1'b0, 8'h00, 1'b1, r, e);
        chk("bw low", {e, r[30:0]}, 32'h0000_0063);
    endtask : t_refuse

    // Reset in mid-run clears the store and the ook, bandwidth and ratio outputs
    task automatic t_rerun();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("held ook", {31'h0, ook_mode}, 32'h0);
        chk("held bw", {18'h0, bw_valid, bw_x10}, 32'h0);
        chk("held osr", {21'h0, osr}, 32'h0);
        presetn <= 1'b1;
        t_reset();
    endtask : t_rerun

    task automatic end_sim();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // Hang guard, far beyond the under two hundred cycles of the run
    initial begin
        #100000;
        err_count++;
        end_sim();
    end

    initial begin
        err_count = 0;
        samples_checked = 0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_row();
        t_manch();
        t_bw();
        t_mod();
        t_refuse();
        t_rerun();
        end_sim();
    end
endmodule : ook_rx_modem_clock_recovery_config_tb_top
